// ---- src/addr_dec_params.svh ----
// address decoder constants and the list of contract items
// assumes inclusion by bare name from package and modules
// Contract
// R01 - boot map puts ROM at address zero
// R02 - first completed write selects normal map
// R03 - normal map never returns without reset
// R04 - ROM word packed from four bytes
// R05 - DRAM sized by module count and organisation
// R06 - RAM reads all bytes, writes masked
// R07 - CBR mode turns DRAM cycles into config
// R08 - WCBR sends address bits, data ignored
// R09 - host reads back, then clears CBR mode
// R10 - SSRAM 128K or 256K, aliased
// R11 - bank bit zero flash, one EPROM
// R12 - swap jumper inverts ROM bank bit
// R13 - EPROM read only, flash writable
// R14 - flash writes low lane, high lines select
// R15 - flash writes non-sequential, uncached
// R16 - host uses low-lane I/O addresses
// R17 - I/O byte masks only partially decoded
// R18 - I/O quadrant split in four regions
// R19 - read/write-abort region aborts every beat
// R20 - read-abort region aborts reads, drops writes
// R21 - legacy memory uses strobes, ready, zero-wait
// R22 - top two address bits pick quadrant
// R23 - bit 25 picks self or external decode
// R24 - boot flag set by reset, cleared once
// R25 - abort regions drive no strobes, complete
`ifndef ADDR_DEC_PARAMS_SVH
`define ADDR_DEC_PARAMS_SVH
`define CLK_MHZ 250
`define ROM_ACC_NS 120
`define ROM_ACC_CYC ((`ROM_ACC_NS * `CLK_MHZ + 999) / 1000)
`define ROM_WR_NS 100
`define ROM_WR_CYC ((`ROM_WR_NS * `CLK_MHZ + 999) / 1000)
`define Q_DRAM 2'h0
`define Q_SSRAM 2'h1
`define Q_ROM 2'h2
`define Q_IO 2'h3
`define IO_R_ABORT 2'h0
`define IO_RW_ABORT 2'h1
`define IO_MEM 2'h2
`define IO_IO 2'h3
`define ROM_SEL_BIT 29
`define IO_EXT_BIT 25
`define DRAM_BASE_BITS 22
`define SSRAM_BITS 17
`define APB_CTRL 12'h000
`define APB_STATUS 12'h004
`define CTRL_CBR 0
`define CTRL_RST 1'h0
`endif

// ---- src/addr_dec_pkg.sv ----
// shared types of the address decoder
// assumes the params header is available
`include "addr_dec_params.svh"
package addr_dec_pkg;
	typedef struct packed {
		logic [31:0] addr;
		logic write;
		logic seq;
		logic [3:0] be;
		logic [31:0] wdata;
	} cpu_req_type;
	typedef enum logic [1:0] {simm_1m, simm_2m, simm_4m} simm_size_type;
	typedef enum logic [2:0] {tgt_dram, tgt_ssram, tgt_flash, tgt_eprom,
		tgt_lio, tgt_lmem, tgt_abort, tgt_ignore} target_type;
	typedef struct packed {
		logic [24:0] addr;
		logic [3:0] be;
		logic write;
		logic cfg;
		logic bank;
		logic [31:0] wdata;
	} dram_cmd_type;
endpackage

// ---- src/rom_packer.sv ----
// byte-wide ROM sequencer: four reads per word, one byte per write
// assumes start is a one-cycle pulse while idle
`timescale 1ns/1ps
`include "addr_dec_params.svh"
module rom_packer #(
	parameter int ACC_CYC = `ROM_ACC_CYC,
	parameter int WR_CYC = `ROM_WR_CYC
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// request
	input wire logic start,
	input wire logic write,
	input wire logic flash,
	input wire logic [19:0] base_addr,
	input wire logic [7:0] wbyte,
	output logic done,
	output logic [31:0] rdata,
	// rom pins
	output logic [19:0] rom_addr,
	output logic flash_ce_n,
	output logic eprom_ce_n,
	output logic rom_oe_n,
	output logic rom_we_n,
	output logic [7:0] rom_data_out,
	output logic rom_data_oe,
	input wire logic [7:0] rom_data_in
);
	typedef enum logic [1:0] {p_idle, p_read, p_write} pstate_type;
	pstate_type state_reg;
	logic [7:0] cnt_reg;
	logic [1:0] idx_reg;
	logic flash_reg;
	logic last;

	assign last = (cnt_reg == 8'h01);
	assign flash_ce_n = !(state_reg != p_idle && flash_reg);
	assign eprom_ce_n = !(state_reg != p_idle && !flash_reg);
	assign rom_oe_n = (state_reg != p_read);
	assign rom_we_n = (state_reg != p_write);
	assign rom_data_oe = (state_reg == p_write);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= p_idle;
			cnt_reg <= 8'h00;
			idx_reg <= 2'h0;
			flash_reg <= 1'b0;
			done <= 1'b0;
			rom_addr <= 20'h00000;
			rom_data_out <= 8'h00;
		end else begin
			done <= 1'b0;
			case (state_reg)
			p_idle: if (start) begin
				flash_reg <= flash;
				rom_addr <= base_addr;
				rom_data_out <= wbyte;
				idx_reg <= 2'h0;
				cnt_reg <= write ? 8'(WR_CYC) : 8'(ACC_CYC);
				state_reg <= write ? p_write : p_read;
			end
			p_read: if (last) begin
				idx_reg <= idx_reg + 2'h1;
				rom_addr[1:0] <= idx_reg + 2'h1; // R04
				cnt_reg <= 8'(ACC_CYC);
				if (idx_reg == 2'h3) begin
					state_reg <= p_idle;
					done <= 1'b1;
				end
			end else begin
				cnt_reg <= cnt_reg - 8'h01;
			end
			p_write: if (last) begin
				state_reg <= p_idle;
				done <= 1'b1;
			end else begin
				cnt_reg <= cnt_reg - 8'h01;
			end
			default: state_reg <= p_idle;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata <= 32'h00000000;
		end else if (state_reg == p_read && last) begin
			rdata[8 * idx_reg +: 8] <= rom_data_in; // R04
		end
	end
endmodule

// ---- src/system_address_decoder.sv ----
// system address decoder between processor bus and memories
// assumes a host holding each beat until cpu_ready, APB for control
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "addr_dec_params.svh"
module system_address_decoder (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// processor bus
	input wire logic cpu_valid,
	input wire addr_dec_pkg::cpu_req_type cpu_req,
	output logic cpu_ready,
	output logic cpu_abort,
	output logic [31:0] cpu_rdata,
	// straps
	input wire logic boot_rom_swap_jumper,
	input wire logic [1:0] simm_count,
	input wire addr_dec_pkg::simm_size_type simm_size,
	input wire logic ssram_large,
	// dram
	output addr_dec_pkg::dram_cmd_type dram_cmd,
	output logic dram_req,
	input wire logic dram_ack,
	input wire logic [31:0] dram_rdata,
	// ssram
	output logic ssram_req,
	output logic [17:0] ssram_addr,
	output logic [3:0] ssram_be,
	output logic ssram_write,
	output logic [31:0] ssram_wdata,
	input wire logic ssram_ack,
	input wire logic [31:0] ssram_rdata,
	// rom
	output logic [19:0] rom_addr,
	output logic flash_ce_n,
	output logic eprom_ce_n,
	output logic rom_oe_n,
	output logic rom_we_n,
	output logic [7:0] rom_data_out,
	output logic rom_data_oe,
	input wire logic [7:0] rom_data_in,
	// legacy bus
	output logic [27:0] legacy_addr,
	output logic [1:0] legacy_be,
	output logic [15:0] legacy_wdata,
	output logic legacy_data_oe,
	input wire logic [15:0] legacy_rdata,
	output logic legacy_io_rd_n,
	output logic legacy_io_wr_n,
	output logic legacy_mem_rd_n,
	output logic legacy_mem_wr_n,
	output logic legacy_io_self_sel,
	output logic legacy_io_ext_sel,
	input wire logic zero_wait_n,
	input wire logic legacy_rdy
);
	import addr_dec_pkg::*;

	typedef enum logic [2:0] {st_idle, st_dram, st_ssram, st_rom, st_leg,
		st_resp} state_type;

	state_type state_reg;
	logic boot_map_reg;
	logic cbr_mode_reg;
	logic wr_reg;
	logic rom_start_reg;
	logic rom_done;
	logic [31:0] rom_word;
	logic leg_mem_reg;
	logic leg_rd_reg;
	logic leg_wr_reg;
	logic rom_addr_eprom;
	logic [19:0] rom_base_reg;
	logic [7:0] rom_wbyte_reg;
	logic apb_hit;
	target_type tgt;

	function automatic target_type rom_pick(logic [31:0] a, logic wr,
		logic swap);
		logic eprom;
		eprom = a[`ROM_SEL_BIT] ^ swap; // R11 R12
		if (!eprom)
			return tgt_flash;
		return wr ? tgt_ignore : tgt_eprom; // R13
	endfunction

	function automatic target_type decode(logic [31:0] a, logic wr,
		logic boot, logic swap);
		target_type t;
		t = tgt_ignore;
		case (a[31:30]) // R22
		`Q_DRAM: t = boot ? rom_pick(a, wr, swap) : tgt_dram; // R01
		`Q_SSRAM: t = tgt_ssram;
		`Q_ROM: t = rom_pick(a, wr, swap);
		`Q_IO: begin
			case (a[29:28]) // R18
			`IO_R_ABORT: t = wr ? tgt_ignore : tgt_abort; // R20
			`IO_RW_ABORT: t = tgt_abort; // R19
			`IO_MEM: t = tgt_lmem;
			default: t = tgt_lio;
			endcase
		end
		default: t = tgt_ignore;
		endcase
		return t;
	endfunction

	function automatic logic [24:0] dram_mask(logic [1:0] cnt,
		simm_size_type sz);
		logic [5:0] bits;
		bits = 6'(`DRAM_BASE_BITS) + 6'(sz) + ((cnt == 2'h2) ? 6'h1 : 6'h0);
		return 25'((34'h1 << bits) - 34'h1); // R05
	endfunction

	assign tgt = decode(cpu_req.addr, cpu_req.write, boot_map_reg,
		boot_rom_swap_jumper);
	assign cpu_ready = (state_reg == st_resp);
	assign legacy_io_rd_n = !(leg_rd_reg && !leg_mem_reg);
	assign legacy_io_wr_n = !(leg_wr_reg && !leg_mem_reg);
	assign legacy_mem_rd_n = !(leg_rd_reg && leg_mem_reg); // R21
	assign legacy_mem_wr_n = !(leg_wr_reg && leg_mem_reg); // R21

	// transfer sequencing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= st_idle;
			wr_reg <= 1'b0;
			cpu_abort <= 1'b0;
			rom_start_reg <= 1'b0;
		end else begin
			rom_start_reg <= 1'b0;
			case (state_reg)
			st_idle: if (cpu_valid) begin
				wr_reg <= cpu_req.write;
				cpu_abort <= (tgt == tgt_abort); // R19 R20
				case (tgt)
				tgt_dram: state_reg <= (simm_count == 2'h0) ? st_resp : st_dram;
				tgt_ssram: state_reg <= st_ssram;
				tgt_flash, tgt_eprom: begin
					state_reg <= st_rom;
					rom_start_reg <= 1'b1;
				end
				tgt_lio, tgt_lmem: state_reg <= st_leg;
				default: state_reg <= st_resp; // R25
				endcase
			end
			st_dram: if (dram_ack) state_reg <= st_resp;
			st_ssram: if (ssram_ack) state_reg <= st_resp;
			st_rom: if (rom_done) state_reg <= st_resp;
			st_leg: if (!zero_wait_n || legacy_rdy) state_reg <= st_resp; // R21
			st_resp: begin
				state_reg <= st_idle;
				cpu_abort <= 1'b0;
			end
			default: state_reg <= st_idle;
			endcase
		end
	end

	// boot map flag, cleared when the first write beat completes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boot_map_reg <= 1'b1; // R24 R01
		end else if (state_reg == st_resp && wr_reg) begin
			boot_map_reg <= 1'b0; // R02 R03 R24
		end
	end

	// read data returned to the processor
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_rdata <= 32'h00000000;
		end else begin
			case (state_reg)
			st_idle: cpu_rdata <= 32'h00000000;
			st_dram: if (dram_ack) cpu_rdata <= dram_rdata;
			st_ssram: if (ssram_ack) cpu_rdata <= ssram_rdata;
			st_rom: if (rom_done) cpu_rdata <= rom_word; // R04
			st_leg: if (!zero_wait_n || legacy_rdy)
				cpu_rdata <= {16'h0000, legacy_rdata};
			default: cpu_rdata <= cpu_rdata;
			endcase
		end
	end

	// dram command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dram_req <= 1'b0;
			dram_cmd <= '0;
		end else if (state_reg == st_idle && cpu_valid && tgt == tgt_dram &&
			simm_count != 2'h0) begin
			dram_req <= 1'b1;
			dram_cmd.addr <= cpu_req.addr[24:0] &
				dram_mask(simm_count, simm_size); // R05 R08
			dram_cmd.bank <= (simm_count == 2'h2) &&
				cpu_req.addr[`DRAM_BASE_BITS + 32'(simm_size)];
			dram_cmd.write <= cpu_req.write;
			dram_cmd.be <= cpu_req.write ? cpu_req.be : 4'hf; // R06
			dram_cmd.cfg <= cbr_mode_reg; // R07
			dram_cmd.wdata <= (cbr_mode_reg && cpu_req.write) ? 32'h00000000 :
				cpu_req.wdata; // R08
		end else if (state_reg == st_dram && dram_ack) begin
			dram_req <= 1'b0;
		end
	end

	// ssram command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ssram_req <= 1'b0;
			ssram_addr <= 18'h00000;
			ssram_be <= 4'h0;
			ssram_write <= 1'b0;
			ssram_wdata <= 32'h00000000;
		end else if (state_reg == st_idle && cpu_valid && tgt == tgt_ssram) begin
			ssram_req <= 1'b1;
			ssram_addr <= ssram_large ? cpu_req.addr[17:0] :
				{1'b0, cpu_req.addr[`SSRAM_BITS - 1:0]}; // R10
			ssram_be <= cpu_req.write ? cpu_req.be : 4'hf; // R06
			ssram_write <= cpu_req.write;
			ssram_wdata <= cpu_req.wdata;
		end else if (state_reg == st_ssram && ssram_ack) begin
			ssram_req <= 1'b0;
		end
	end

	// legacy bus cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			leg_mem_reg <= 1'b0;
			leg_rd_reg <= 1'b0;
			leg_wr_reg <= 1'b0;
			legacy_addr <= 28'h0000000;
			legacy_be <= 2'h0;
			legacy_wdata <= 16'h0000;
			legacy_data_oe <= 1'b0;
			legacy_io_self_sel <= 1'b0;
			legacy_io_ext_sel <= 1'b0;
		end else if (state_reg == st_idle && cpu_valid &&
			(tgt == tgt_lio || tgt == tgt_lmem)) begin
			leg_mem_reg <= (tgt == tgt_lmem);
			leg_rd_reg <= !cpu_req.write;
			leg_wr_reg <= cpu_req.write;
			legacy_addr <= cpu_req.addr[27:0];
			legacy_be <= cpu_req.be[1:0]; // R17
			legacy_wdata <= cpu_req.wdata[15:0];
			legacy_data_oe <= cpu_req.write;
			legacy_io_self_sel <= (tgt == tgt_lio) &&
				!cpu_req.addr[`IO_EXT_BIT]; // R23
			legacy_io_ext_sel <= (tgt == tgt_lio) &&
				cpu_req.addr[`IO_EXT_BIT]; // R23
		end else if (state_reg == st_leg && (!zero_wait_n || legacy_rdy)) begin
			leg_rd_reg <= 1'b0;
			leg_wr_reg <= 1'b0;
			legacy_data_oe <= 1'b0;
			legacy_io_self_sel <= 1'b0;
			legacy_io_ext_sel <= 1'b0;
		end
	end

	rom_packer u_rom_packer (
		.pclk(pclk),
		.presetn(presetn),
		.start(rom_start_reg),
		.write(wr_reg),
		.flash(state_reg == st_rom && !rom_addr_eprom),
		.base_addr(rom_base_reg),
		.wbyte(rom_wbyte_reg),
		.done(rom_done),
		.rdata(rom_word),
		.rom_addr(rom_addr),
		.flash_ce_n(flash_ce_n),
		.eprom_ce_n(eprom_ce_n),
		.rom_oe_n(rom_oe_n),
		.rom_we_n(rom_we_n),
		.rom_data_out(rom_data_out),
		.rom_data_oe(rom_data_oe),
		.rom_data_in(rom_data_in)
	);

	// rom request, flash byte chosen by high address lines on writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rom_addr_eprom <= 1'b0;
			rom_base_reg <= 20'h00000;
			rom_wbyte_reg <= 8'h00;
		end else if (state_reg == st_idle && cpu_valid &&
			(tgt == tgt_flash || tgt == tgt_eprom)) begin
			rom_addr_eprom <= (tgt == tgt_eprom);
			rom_base_reg[19:2] <= (tgt == tgt_eprom) ?
				{1'b0, cpu_req.addr[18:2]} : cpu_req.addr[19:2]; // R13
			rom_base_reg[1:0] <= cpu_req.write ? cpu_req.addr[23:22] :
				2'h0; // R14 R04
			rom_wbyte_reg <= cpu_req.wdata[7:0]; // R14
		end
	end

	// apb control and status
	assign apb_hit = (paddr == `APB_CTRL) || (paddr == `APB_STATUS);
	assign pready = penable;
	assign pslverr = psel && penable && !apb_hit;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cbr_mode_reg <= `CTRL_RST;
		end else if (psel && penable && pwrite && paddr == `APB_CTRL) begin
			cbr_mode_reg <= pwdata[`CTRL_CBR]; // R07 R09
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable) begin
			if (paddr == `APB_CTRL)
				prdata <= {31'h00000000, cbr_mode_reg};
			else if (paddr == `APB_STATUS)
				prdata <= {24'h000000, state_reg != st_idle, simm_size,
					simm_count, ssram_large, boot_rom_swap_jumper, boot_map_reg};
			else
				prdata <= 32'h00000000;
		end
	end

	chk_boot_stays_off: assert property (@(posedge pclk) // R03
		disable iff (!presetn) !boot_map_reg |=> !boot_map_reg)
		else $error("boot map came back");
	chk_first_write_clears: assert property (@(posedge pclk) // R02
		disable iff (!presetn)
		cpu_ready && wr_reg |=> !boot_map_reg)
		else $error("write did not leave boot map");
	chk_boot_zero_rom: assert property (@(posedge pclk) // R01
		disable iff (!presetn) state_reg == st_idle && cpu_valid &&
		boot_map_reg && cpu_req.addr[31:30] == `Q_DRAM |=> !dram_req)
		else $error("boot alias reached dram");
	chk_rw_abort_beat: assert property (@(posedge pclk) // R19
		disable iff (!presetn) state_reg == st_idle && cpu_valid &&
		cpu_req.addr[31:28] == {`Q_IO, `IO_RW_ABORT}
		|=> cpu_ready && cpu_abort)
		else $error("rw abort missing");
	chk_r_abort_write: assert property (@(posedge pclk) // R20
		disable iff (!presetn) state_reg == st_idle && cpu_valid &&
		cpu_req.addr[31:28] == {`Q_IO, `IO_R_ABORT}
		|=> cpu_ready && (cpu_abort == !$past(cpu_req.write)))
		else $error("read abort region misbehaved");
	chk_abort_quiet: assert property (@(posedge pclk) // R25
		disable iff (!presetn)
		cpu_abort |-> legacy_mem_rd_n && legacy_mem_wr_n && legacy_io_rd_n &&
		legacy_io_wr_n && !dram_req && !ssram_req && rom_oe_n && rom_we_n)
		else $error("strobe during abort");
	chk_dram_read_bytes: assert property (@(posedge pclk) // R06
		disable iff (!presetn)
		dram_req && !dram_cmd.write |-> dram_cmd.be == 4'hf)
		else $error("partial dram read");
	chk_wcbr_data: assert property (@(posedge pclk) // R08
		disable iff (!presetn) dram_req && dram_cmd.cfg && dram_cmd.write |->
		dram_cmd.wdata == 32'h00000000)
		else $error("wcbr carried data");
	chk_mem_strobe_end: assert property (@(posedge pclk) // R21
		disable iff (!presetn)
		!legacy_mem_rd_n && (!zero_wait_n || legacy_rdy) |=>
		legacy_mem_rd_n ##1 cpu_ready == 1'b0)
		else $error("memory strobe held");
endmodule

// ---- test/mem_partner.sv ----
// model of the memories and legacy devices behind the decoder
// assumes the decoder holds each request until its acknowledge
`timescale 1ns/1ps
module mem_partner (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// pacing
	input wire logic slow,
	// dram
	input wire addr_dec_pkg::dram_cmd_type dram_cmd,
	input wire logic dram_req,
	output logic dram_ack,
	output logic [31:0] dram_rdata,
	// ssram
	input wire logic ssram_req,
	input wire logic [17:0] ssram_addr,
	input wire logic [3:0] ssram_be,
	input wire logic ssram_write,
	input wire logic [31:0] ssram_wdata,
	output logic ssram_ack,
	output logic [31:0] ssram_rdata,
	// rom
	input wire logic [19:0] rom_addr,
	input wire logic rom_oe_n,
	output logic [7:0] rom_data_in,
	// legacy bus
	input wire logic legacy_io_rd_n,
	input wire logic legacy_io_wr_n,
	input wire logic legacy_mem_rd_n,
	input wire logic legacy_mem_wr_n,
	output logic [15:0] legacy_rdata,
	output logic zero_wait_n,
	output logic legacy_rdy
);
	import addr_dec_pkg::*;
	logic [31:0] dmem [logic [24:0]];
	logic [31:0] smem [logic [17:0]];
	logic [3:0] wait_cnt, leg_cnt;
	logic io_act, mem_act;
	function automatic logic [31:0] merge(input logic [31:0] o, n,
		input logic [3:0] be);
		for (int b = 0; b < 4; b++)
			if (be[b])
				o[8*b +: 8] = n[8*b +: 8];
		return o;
	endfunction
	// byte follows address while enabled, inverted when released
	assign rom_data_in = rom_oe_n ? ~(rom_addr[7:0] + 8'h11) :
		rom_addr[7:0] + 8'h11;
	assign io_act = !legacy_io_rd_n || !legacy_io_wr_n;
	assign mem_act = !legacy_mem_rd_n || !legacy_mem_wr_n;
	assign zero_wait_n = !(io_act && leg_cnt >= 4'h1);
	assign legacy_rdy = mem_act && leg_cnt >= 4'h3;
	assign legacy_rdata = (io_act || mem_act) ? 16'h5aa5 : 16'ha55a;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			leg_cnt <= 4'h0;
		else
			leg_cnt <= (io_act || mem_act) ? leg_cnt + 4'h1 : 4'h0;
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dram_ack <= 1'b0;
			wait_cnt <= 4'h0;
			dram_rdata <= 32'h0;
		end else begin
			dram_ack <= 1'b0;
			dram_rdata <= ~dram_rdata;
			if (dram_req && !dram_ack) begin
				wait_cnt <= wait_cnt + 4'h1;
				if (wait_cnt >= (slow ? 4'h5 : 4'h0)) begin
					dram_ack <= 1'b1;
					wait_cnt <= 4'h0;
					if (dram_cmd.write && !dram_cmd.cfg)
						dmem[dram_cmd.addr] = merge(dmem.exists(dram_cmd.addr) ?
							dmem[dram_cmd.addr] : 32'h0, dram_cmd.wdata, dram_cmd.be);
					else
						dram_rdata <= dmem.exists(dram_cmd.addr) ?
							dmem[dram_cmd.addr] : 32'h0;
				end
			end
		end
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ssram_ack <= 1'b0;
			ssram_rdata <= 32'h0;
		end else begin
			ssram_ack <= ssram_req && !ssram_ack;
			ssram_rdata <= ~ssram_rdata;
			if (ssram_req && !ssram_ack) begin
				if (ssram_write)
					smem[ssram_addr] = merge(smem.exists(ssram_addr) ?
						smem[ssram_addr] : 32'h0, ssram_wdata, ssram_be);
				else
					ssram_rdata <= smem.exists(ssram_addr) ? smem[ssram_addr] : 32'h0;
			end
		end
	end
endmodule

// ---- test/tb.sv ----
// self-checking bench of the system address decoder
// assumes mem_partner answers the memory and legacy pins
`timescale 1ns/1ps
module tb;
	import addr_dec_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, cpu_rdata, dram_rdata, r;
	logic [31:0] ssram_rdata, ssram_wdata;
	logic pready, pslverr, cpu_ready, cpu_abort, dram_req, dram_ack, ab, e;
	logic cpu_valid = 0, boot_rom_swap_jumper = 0, ssram_large = 0;
	logic slow = 0, burst = 0;
	logic [1:0] simm_count = 2'h1;
	simm_size_type simm_size = simm_4m;
	cpu_req_type cpu_req = '0;
	dram_cmd_type dram_cmd, last_cmd;
	logic ssram_req, ssram_write, ssram_ack, flash_ce_n, eprom_ce_n;
	logic rom_oe_n, rom_we_n, rom_data_oe, legacy_data_oe, legacy_io_rd_n;
	logic legacy_io_wr_n, legacy_mem_rd_n, legacy_mem_wr_n;
	logic legacy_io_self_sel, legacy_io_ext_sel, zero_wait_n, legacy_rdy;
	logic [17:0] ssram_addr;
	logic [3:0] ssram_be;
	logic [19:0] rom_addr, wr_addr;
	logic [7:0] rom_data_out, rom_data_in, wr_byte;
	logic [27:0] legacy_addr;
	logic [1:0] legacy_be;
	logic [15:0] legacy_wdata, legacy_rdata;
	logic [8:0] seen;
	int miscompares = 0, n_tests = 0, cycles = 0;
	system_address_decoder DUT (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .cpu_valid, .cpu_req,
		.cpu_ready, .cpu_abort, .cpu_rdata, .boot_rom_swap_jumper, .simm_count,
		.simm_size, .ssram_large, .dram_cmd, .dram_req, .dram_ack, .dram_rdata,
		.ssram_req, .ssram_addr, .ssram_be, .ssram_write, .ssram_wdata,
		.ssram_ack, .ssram_rdata, .rom_addr, .flash_ce_n, .eprom_ce_n, .rom_oe_n,
		.rom_we_n, .rom_data_out, .rom_data_oe, .rom_data_in, .legacy_addr,
		.legacy_be, .legacy_wdata, .legacy_data_oe, .legacy_rdata,
		.legacy_io_rd_n, .legacy_io_wr_n, .legacy_mem_rd_n, .legacy_mem_wr_n,
		.legacy_io_self_sel, .legacy_io_ext_sel, .zero_wait_n, .legacy_rdy);
	mem_partner model (.pclk, .presetn, .slow, .dram_cmd, .dram_req, .dram_ack,
		.dram_rdata, .ssram_req, .ssram_addr, .ssram_be, .ssram_write,
		.ssram_wdata, .ssram_ack, .ssram_rdata, .rom_addr, .rom_oe_n,
		.rom_data_in, .legacy_io_rd_n, .legacy_io_wr_n, .legacy_mem_rd_n,
		.legacy_mem_wr_n, .legacy_rdata, .zero_wait_n, .legacy_rdy);
	always #2 pclk = ~pclk;
	// what each beat touched: romwe ssram legacy ext self cfg dram eprom flash
	always @(posedge pclk) begin
		if (!cpu_valid)
			seen <= 9'h0;
		else
			seen <= seen | {!rom_we_n, ssram_req, !(legacy_io_rd_n &&
				legacy_io_wr_n && legacy_mem_rd_n && legacy_mem_wr_n),
				legacy_io_ext_sel, legacy_io_self_sel, dram_req && dram_cmd.cfg,
				dram_req, !eprom_ce_n, !flash_ce_n};
		if (!rom_we_n) begin
			wr_addr <= rom_addr;
			wr_byte <= rom_data_oe ? rom_data_out : 8'h00;
		end
		if (dram_req)
			last_cmd <= dram_cmd;
	end
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			miscompares++;
			results();
		end
	end
	task automatic chk(input logic [31:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic see(input logic [8:0] mask, exp);
		chk({23'h0, seen & mask}, {23'h0, exp});
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic cpu(input logic [31:0] a, input logic w,
		input logic [3:0] be, input logic [31:0] wd);
		@(posedge pclk);
		cpu_req <= '{a, w, burst, be, wd};
		cpu_valid <= 1'b1;
		@(posedge pclk);
		while (cpu_ready !== 1'b1)
			@(posedge pclk);
		r = cpu_rdata;
		ab = cpu_abort;
		cpu_valid <= 1'b0;
	endtask
	task automatic do_reset();
		presetn <= 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		do_reset();
		apb(1'b0, 12'h000, 32'h0);
		chk(r, 32'h0);
		apb(1'b0, 12'h004, 32'h0);
		chk(r & 32'h3, 32'h1);
		apb(1'b0, 12'h008, 32'h0);
		chk({31'h0, e}, 32'h1);
		$display("test registers done");
		cpu(32'h0000_0010, 1'b0, 4'hf, 32'h0);
		chk(r, 32'h2423_2221);
		see(9'h007, 9'h001);
		cpu(32'h8000_0010, 1'b0, 4'hf, 32'h0);
		chk(r, 32'h2423_2221);
		cpu(32'h0000_0000, 1'b1, 4'h1, 32'h0000_00ab);
		see(9'h104, 9'h100);
		chk({24'h0, wr_byte}, 32'hab);
		apb(1'b0, 12'h004, 32'h0);
		chk(r & 32'h1, 32'h0);
		cpu(32'h0000_0000, 1'b1, 4'hf, 32'hdead_beef);
		see(9'h104, 9'h004);
		slow <= 1'b1;
		cpu(32'h0000_0000, 1'b1, 4'h2, 32'h0000_1100);
		cpu(32'h0000_0000, 1'b0, 4'hf, 32'h0);
		chk(r, 32'hdead_11ef);
		see(9'h007, 9'h004);
		cpu(32'h0100_0000, 1'b0, 4'hf, 32'h0);
		chk(r, 32'hdead_11ef);
		$display("test boot map done");
		cpu(32'h8040_0004, 1'b1, 4'h1, 32'h0000_005a);
		chk({12'h0, wr_addr}, 32'h5);
		cpu(32'ha000_0010, 1'b0, 4'hf, 32'h0);
		see(9'h003, 9'h002);
		cpu(32'ha000_0000, 1'b1, 4'h1, 32'h0000_0077);
		see(9'h100, 9'h000);
		$display("test rom banks done");
		cpu(32'h4000_0020, 1'b1, 4'hf, 32'h1122_3344);
		cpu(32'h4002_0020, 1'b1, 4'h1, 32'h0000_00aa);
		ssram_large <= 1'b1;
		cpu(32'h4002_0020, 1'b1, 4'hf, 32'h0000_0055);
		cpu(32'h4000_0020, 1'b0, 4'hf, 32'h0);
		chk(r, 32'h1122_33aa);
		see(9'h080, 9'h080);
		$display("test ssram done");
		for (int i = 0; i < 8; i++) begin
			burst = i[2];
			cpu(i[1] ? 32'hd000_0000 : 32'hc000_0000, i[0], 4'hf, 32'h0);
			chk({31'h0, ab}, {31'h0, i[1] | ~i[0]});
			see(9'h1c7, 9'h000);
		end
		burst = 1'b0;
		$display("test abort regions done");
		cpu(32'he000_0000, 1'b0, 4'hf, 32'h0);
		see(9'h070, 9'h040);
		chk(r & 32'hffff, 32'h5aa5);
		cpu(32'hf000_0000, 1'b0, 4'h1, 32'h0);
		see(9'h070, 9'h050);
		cpu(32'hf200_0000, 1'b1, 4'h1, 32'h0000_0012);
		see(9'h070, 9'h060);
		chk({4'h0, legacy_addr}, 32'h0200_0000);
		chk({30'h0, legacy_be}, 32'h1);
		chk({16'h0, legacy_wdata}, 32'h12);
		$display("test legacy bus done");
		apb(1'b1, 12'h000, 32'h1);
		cpu(32'h0000_0088, 1'b1, 4'hf, 32'hffff_ffff);
		see(9'h008, 9'h008);
		chk(last_cmd.wdata, 32'h0);
		chk({24'h0, last_cmd.addr[7:0]}, 32'h88);
		cpu(32'h0000_0088, 1'b0, 4'hf, 32'h0);
		see(9'h008, 9'h008);
		apb(1'b1, 12'h000, 32'h0);
		cpu(32'h0000_0000, 1'b0, 4'hf, 32'h0);
		see(9'h008, 9'h000);
		simm_count <= 2'h0;
		cpu(32'h0000_0000, 1'b0, 4'hf, 32'h0);
		chk(r, 32'h0);
		$display("test dram config done");
		boot_rom_swap_jumper <= 1'b1;
		do_reset();
		apb(1'b0, 12'h004, 32'h0);
		chk(r & 32'h3, 32'h3);
		cpu(32'h0000_0010, 1'b0, 4'hf, 32'h0);
		see(9'h003, 9'h002);
		$display("test swap jumper done");
		results();
	end
endmodule
